// ---- tlic_ctrl.sv ----
// Purpose: Two-level interrupt controller with vector generation
// Assumes: Requests are level flags held by peripherals on mclk; core acks each vector
// Notes: One vector is offered at a time; the core acks it and later signals return
// Function
// - Eleven sources, each except the watchdog assignable to low or high level
// - Main enable bit 7 gates every maskable source
// - Main enable holds per-source enable bits in fixed positions
// - Priority register mirrors enable order, bit 7 reserved, 1 is high
// - Secondary bits 6,5,4 set interval, supply monitor, SPI levels
// - Secondary bits 2,1,0 enable interval, supply monitor, SPI
// - Enabled high request preempts a low-level handler
// - Simultaneous different levels: high level vectored first
// - No preemption of a handler at the same level
// - Equal levels resolved by fixed polling order
// - Acceptance pushes program counter and loads the vector
// - Each source has its fixed vector address
// - Watchdog in interrupt mode raises request vectored to 005Bh
// - Watchdog is always high level and ignores global enable
// - Watchdog request only when timeout setting is nonzero
`timescale 1ns/10ps

module tlic_ctrl
(
    input wire logic mclk,
    input wire logic nrst,
    // Register port of the core
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Source flags
    input wire logic supply_mon_request,
    input wire logic watchdog_timeout,
    input wire logic watchdog_irq_mode,
    input wire logic [3:0] watchdog_timeout_sel,
    input wire logic ext0_request,
    input wire logic conv_done_request,
    input wire logic tmr0_overflow_flag,
    input wire logic ext1_request,
    input wire logic tmr1_overflow_flag,
    input wire logic spi_request,
    input wire logic uart_rx_flag,
    input wire logic uart_tx_flag,
    input wire logic tmr2_overflow_flag,
    input wire logic tmr2_external_flag,
    input wire logic interval_request,
    // Core handshake
    input wire logic irq_ack,
    input wire logic reti_exec,
    output logic irq_req,
    output logic [15:0] irq_vector,
    output logic irq_push_pc,
    output logic irq_high_level,
    output logic [1:0] active_levels
);

    // ==========================================================
    // Registers
    logic [7:0] ie_q;
    logic [7:0] ip_q;
    logic [7:0] sec_q;
    logic [7:0] rdata_q;
    logic low_act_q;
    logic high_act_q;
    logic req_q;
    logic [15:0] vec_q;
    logic push_q;
    logic lvl_q;
    tlic_pkg::tlic_state_e state_q;

    // Vector lookup by source index
    function automatic logic [15:0] src_vector(input logic [3:0] idx);
        logic [15:0] v;
        v = tlic_pkg::VEC_INTERVAL;
        case (idx)
            4'h0: v = tlic_pkg::VEC_SUPPLY;
            4'h1: v = tlic_pkg::VEC_WDOG;
            4'h2: v = tlic_pkg::VEC_EXT0;
            4'h3: v = tlic_pkg::VEC_CONV;
            4'h4: v = tlic_pkg::VEC_TMR0;
            4'h5: v = tlic_pkg::VEC_EXT1;
            4'h6: v = tlic_pkg::VEC_TMR1;
            4'h7: v = tlic_pkg::VEC_SPI;
            4'h8: v = tlic_pkg::VEC_UART;
            4'h9: v = tlic_pkg::VEC_TMR2;
            default: v = tlic_pkg::VEC_INTERVAL;
        endcase
        return v;
    endfunction

    // First set bit in polling order
    function automatic logic [3:0] first_set(input logic [10:0] m);
        logic [3:0] r;
        r = 4'hf;
        for (int i = tlic_pkg::NSRC - 1; i >= 0; i--)
        begin
            if (m[i])
            begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // ==========================================================
    // Source requests, enables and levels in polling order
    wire logic wdog_req = watchdog_irq_mode && watchdog_timeout
                          && (watchdog_timeout_sel != 4'h0);
    wire logic uart_req = uart_rx_flag | uart_tx_flag;
    wire logic tmr2_req = tmr2_overflow_flag | tmr2_external_flag;
    wire logic [10:0] raw_req = {interval_request, tmr2_req, uart_req, spi_request,
                                 tmr1_overflow_flag, ext1_request, tmr0_overflow_flag,
                                 conv_done_request, ext0_request, wdog_req,
                                 supply_mon_request};
    // Global gate leaves the watchdog slot alone
    wire logic ge = ie_q[tlic_pkg::GLOBAL_BIT];
    wire logic [10:0] src_en = {sec_q[tlic_pkg::INTERVAL_EN_BIT] & ge,
                                ie_q[tlic_pkg::TMR2_BIT] & ge,
                                ie_q[tlic_pkg::UART_BIT] & ge,
                                sec_q[tlic_pkg::SPI_EN_BIT] & ge,
                                ie_q[tlic_pkg::TMR1_BIT] & ge,
                                ie_q[tlic_pkg::EXT1_BIT] & ge,
                                ie_q[tlic_pkg::TMR0_BIT] & ge,
                                ie_q[tlic_pkg::CONV_BIT] & ge,
                                ie_q[tlic_pkg::EXT0_BIT] & ge,
                                1'b1,
                                sec_q[tlic_pkg::SUPPLY_EN_BIT] & ge};
    wire logic [10:0] src_hi = {sec_q[tlic_pkg::INTERVAL_LVL_BIT],
                                ip_q[tlic_pkg::TMR2_BIT],
                                ip_q[tlic_pkg::UART_BIT],
                                sec_q[tlic_pkg::SPI_LVL_BIT],
                                ip_q[tlic_pkg::TMR1_BIT],
                                ip_q[tlic_pkg::EXT1_BIT],
                                ip_q[tlic_pkg::TMR0_BIT],
                                ip_q[tlic_pkg::CONV_BIT],
                                ip_q[tlic_pkg::EXT0_BIT],
                                1'b1,
                                sec_q[tlic_pkg::SUPPLY_LVL_BIT]};
    wire logic [10:0] pend = raw_req & src_en;
    wire logic [10:0] pend_hi = pend & src_hi;
    wire logic [10:0] pend_lo = pend & ~src_hi;

    // ==========================================================
    // Arbitration: high level beats low, then polling order
    wire logic can_hi = !high_act_q && (pend_hi != 11'h000);
    wire logic can_lo = !high_act_q && !low_act_q && (pend_lo != 11'h000);
    wire logic take_hi = can_hi;
    wire logic [3:0] win_idx = take_hi ? first_set(pend_hi) : first_set(pend_lo);
    wire logic any_take = can_hi || can_lo;
    wire logic accept = (state_q == tlic_pkg::TLIC_REQ) && irq_ack;

    // ==========================================================
    // Register decode
    wire logic wr_ie = sfr_wr && (sfr_addr == tlic_pkg::ADDR_INTERRUPT_ENABLE);
    wire logic wr_sec = sfr_wr && (sfr_addr == tlic_pkg::ADDR_SECONDARY_ENABLE_PRIORITY);
    wire logic wr_ip = sfr_wr && (sfr_addr == tlic_pkg::ADDR_INTERRUPT_PRIORITY);
    logic [7:0] rdata_d;
    always_comb
    begin
        if (sfr_addr == tlic_pkg::ADDR_INTERRUPT_ENABLE)
        begin
            rdata_d = ie_q;
        end
        else if (sfr_addr == tlic_pkg::ADDR_SECONDARY_ENABLE_PRIORITY)
        begin
            rdata_d = sec_q;
        end
        else if (sfr_addr == tlic_pkg::ADDR_INTERRUPT_PRIORITY)
        begin
            rdata_d = ip_q;
        end
        else
        begin
            rdata_d = 8'h00;
        end
    end

    // Configuration registers; writes store zero in reserved bits so a stray one
    // in secondary bit 3 cannot change behaviour
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            ie_q <= tlic_pkg::RST_INTERRUPT_ENABLE;
            ip_q <= tlic_pkg::RST_INTERRUPT_PRIORITY;
            sec_q <= tlic_pkg::RST_SECONDARY_ENABLE_PRIORITY;
            rdata_q <= 8'h00;
        end
        else
        begin
            if (wr_ie)
                ie_q <= sfr_wdata;
            if (wr_ip)
                ip_q <= sfr_wdata & tlic_pkg::PRIORITY_WMASK;
            if (wr_sec)
                sec_q <= sfr_wdata & tlic_pkg::SECONDARY_WMASK;
            rdata_q <= rdata_d;
        end
    end

    // ==========================================================
    // Request state: offer winner, hold until the core acks or no request can be taken
    // Winner is re-evaluated while offering so a late high request wins
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= tlic_pkg::TLIC_IDLE;
            req_q <= 1'b0;
            vec_q <= 16'h0000;
            lvl_q <= 1'b0;
            push_q <= 1'b0;
        end
        else
        begin
            push_q <= accept;
            case (state_q)
                tlic_pkg::TLIC_IDLE:
                begin
                    if (any_take)
                    begin
                        state_q <= tlic_pkg::TLIC_REQ;
                        req_q <= 1'b1;
                        vec_q <= src_vector(win_idx);
                        lvl_q <= take_hi;
                    end
                end
                tlic_pkg::TLIC_REQ:
                begin
                    if (irq_ack || !any_take)
                    begin
                        state_q <= tlic_pkg::TLIC_IDLE;
                        req_q <= 1'b0;
                    end
                    else
                    begin
                        vec_q <= src_vector(win_idx);
                        lvl_q <= take_hi;
                    end
                end
                default:
                begin
                    state_q <= tlic_pkg::TLIC_IDLE;
                    req_q <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Active service levels; return releases the higher one first
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            low_act_q <= 1'b0;
            high_act_q <= 1'b0;
        end
        else if (accept)
        begin
            if (lvl_q)
                high_act_q <= 1'b1;
            else
                low_act_q <= 1'b1;
        end
        else if (reti_exec)
        begin
            if (high_act_q)
                high_act_q <= 1'b0;
            else
                low_act_q <= 1'b0;
        end
    end

    // Outputs come straight from registers
    assign sfr_rdata = rdata_q;
    assign irq_req = req_q;
    assign irq_vector = vec_q;
    assign irq_push_pc = push_q;
    assign irq_high_level = lvl_q;
    assign active_levels = {high_act_q, low_act_q};

    // ==========================================================
    // Checks
    // Idle flag shared by the checks below
    wire logic st_idle = (state_q == tlic_pkg::TLIC_IDLE);

    // A running high handler admits no further vector at all
    a_high_no_nest: assert property (@(posedge mclk) disable iff (!nrst)
        high_act_q |-> !accept)
        else $error("vector accepted while high handler active");

    // Low request stays parked behind a running low handler
    a_low_blocked: assert property (@(posedge mclk) disable iff (!nrst)
        (st_idle && low_act_q && pend_hi == 11'h000) |=> !req_q)
        else $error("low request offered during low handler");

    // Pending high request interrupts a low handler
    a_high_preempt: assert property (@(posedge mclk) disable iff (!nrst)
        (st_idle && low_act_q && !high_act_q && pend_hi != 11'h000) |=> req_q && lvl_q)
        else $error("high request did not preempt low handler");

    // Mixed levels arriving together: high wins
    a_high_first: assert property (@(posedge mclk) disable iff (!nrst)
        (st_idle && !high_act_q && !low_act_q && pend_hi != 11'h000 && pend_lo != 11'h000)
        |=> lvl_q)
        else $error("low level chosen over high");

    // Equal low levels: external 0 beats every later source
    a_poll_order: assert property (@(posedge mclk) disable iff (!nrst)
        (st_idle && !high_act_q && !low_act_q && pend_hi == 11'h000
         && !pend[tlic_pkg::SRC_SUPPLY] && pend[tlic_pkg::SRC_EXT0])
        |=> vec_q == tlic_pkg::VEC_EXT0)
        else $error("polling order not kept");

    // Watchdog is offered at high level whatever the gate says
    a_wdog_vector: assert property (@(posedge mclk) disable iff (!nrst)
        (st_idle && !high_act_q && !pend[tlic_pkg::SRC_SUPPLY]
         && pend_hi[tlic_pkg::SRC_WDOG])
        |=> vec_q == tlic_pkg::VEC_WDOG && lvl_q)
        else $error("watchdog not vectored at high level");

    // Zero timeout setting never raises the watchdog request
    a_wdog_zero: assert property (@(posedge mclk) disable iff (!nrst)
        (watchdog_timeout_sel == 4'h0) |-> !wdog_req)
        else $error("watchdog request with zero timeout");

    // Clear gate leaves only the watchdog able to pend
    a_global_gate: assert property (@(posedge mclk) disable iff (!nrst)
        !ge |-> (pend & ~(11'h001 << tlic_pkg::SRC_WDOG)) == 11'h000)
        else $error("maskable source pending with global gate clear");

    // Acceptance drops the offer and pulses the push exactly once
    a_ack_drop: assert property (@(posedge mclk) disable iff (!nrst)
        (req_q && irq_ack) |=> !req_q)
        else $error("offer still standing after acceptance");
    a_push_after: assert property (@(posedge mclk) disable iff (!nrst)
        (req_q && irq_ack) |=> irq_push_pc ##1 !irq_push_pc)
        else $error("push pulse not issued after acceptance");

    // Accepted high level becomes active; return releases the higher one
    a_level_track: assert property (@(posedge mclk) disable iff (!nrst)
        (accept && lvl_q) |=> high_act_q)
        else $error("accepted high level not marked active");
    a_reti_release: assert property (@(posedge mclk) disable iff (!nrst)
        (reti_exec && !accept && high_act_q) |=> !high_act_q && $stable(low_act_q))
        else $error("return did not release high level");

    // Secondary bit 3 and priority bit 7 never hold a one
    a_sec_rsvd: assert property (@(posedge mclk) disable iff (!nrst)
        !sec_q[tlic_pkg::SEC_RSVD_BIT] && !ip_q[tlic_pkg::GLOBAL_BIT])
        else $error("reserved bit stored");

endmodule

// ---- tlic_pkg.sv ----
// Purpose: Constants shared by the two-level interrupt controller
// Assumes: 8-bit special-function register bus of the core
// Notes: Vector addresses are 16-bit program addresses
package tlic_pkg;

    // ==========================================================
    // Register addresses
    localparam logic [7:0] ADDR_INTERRUPT_ENABLE = 8'ha8;
    localparam logic [7:0] ADDR_SECONDARY_ENABLE_PRIORITY = 8'ha9;
    localparam logic [7:0] ADDR_INTERRUPT_PRIORITY = 8'hb8;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_INTERRUPT_ENABLE = 8'h00;
    localparam logic [7:0] RST_SECONDARY_ENABLE_PRIORITY = 8'ha0;
    localparam logic [7:0] RST_INTERRUPT_PRIORITY = 8'h00;

    // ==========================================================
    // Field positions, main enable and priority registers
    localparam int GLOBAL_BIT = 7;
    localparam int CONV_BIT = 6;
    localparam int TMR2_BIT = 5;
    localparam int UART_BIT = 4;
    localparam int TMR1_BIT = 3;
    localparam int EXT1_BIT = 2;
    localparam int TMR0_BIT = 1;
    localparam int EXT0_BIT = 0;

    // Field positions, secondary register
    localparam int INTERVAL_LVL_BIT = 6;
    localparam int SUPPLY_LVL_BIT = 5;
    localparam int SPI_LVL_BIT = 4;
    localparam int SEC_RSVD_BIT = 3;
    localparam int INTERVAL_EN_BIT = 2;
    localparam int SUPPLY_EN_BIT = 1;
    localparam int SPI_EN_BIT = 0;

    // Writable masks; a write stores zero in reserved bits, but secondary bit 7 resets to one
    localparam logic [7:0] PRIORITY_WMASK = 8'h7f;
    localparam logic [7:0] SECONDARY_WMASK = 8'h77;

    // ==========================================================
    // Source index in polling order, 0 is polled first
    localparam int NSRC = 11;
    localparam int SRC_SUPPLY = 0;
    localparam int SRC_WDOG = 1;
    localparam int SRC_EXT0 = 2;
    localparam int SRC_CONV = 3;
    localparam int SRC_TMR0 = 4;
    localparam int SRC_EXT1 = 5;
    localparam int SRC_TMR1 = 6;
    localparam int SRC_SPI = 7;
    localparam int SRC_UART = 8;
    localparam int SRC_TMR2 = 9;
    localparam int SRC_INTERVAL = 10;

    // ==========================================================
    // Vector addresses
    localparam logic [15:0] VEC_EXT0 = 16'h0003;
    localparam logic [15:0] VEC_TMR0 = 16'h000b;
    localparam logic [15:0] VEC_EXT1 = 16'h0013;
    localparam logic [15:0] VEC_TMR1 = 16'h001b;
    localparam logic [15:0] VEC_UART = 16'h0023;
    localparam logic [15:0] VEC_TMR2 = 16'h002b;
    localparam logic [15:0] VEC_CONV = 16'h0033;
    localparam logic [15:0] VEC_SPI = 16'h003b;
    localparam logic [15:0] VEC_SUPPLY = 16'h0043;
    localparam logic [15:0] VEC_INTERVAL = 16'h0053;
    localparam logic [15:0] VEC_WDOG = 16'h005b;

    typedef enum logic [1:0] {TLIC_IDLE, TLIC_REQ} tlic_state_e;

endpackage

// ---- tlic_core_model.sv ----
// Purpose: Core-side model that takes offered vectors and returns from handlers
// Assumes: Offers are held until acknowledged; acks are driven on the falling edge
// Notes: Ack is a single pulse so one offer is never taken twice
`timescale 1ns/10ps

module tlic_core_model
(
    input wire logic mclk,
    input wire logic irq_req,
    input wire logic [15:0] irq_vector,
    input wire logic irq_high_level,
    input wire logic irq_push_pc,
    output logic irq_ack,
    output logic reti_exec
);
    logic [15:0] taken_vec;
    logic taken_lvl;
    int taken_cnt;
    int push_cnt;

    // ==========================================================
    // Handshake
    initial
    begin
        irq_ack = 1'b0;
        reti_exec = 1'b0;
        taken_cnt = 0;
        push_cnt = 0;
    end

    // Ack only while an offer stands, never two cycles running
    always @(negedge mclk)
        irq_ack <= irq_req && !irq_ack;

    // Record the offer at the edge that samples the ack, and count pushes
    always @(posedge mclk)
    begin
        if (irq_ack && irq_req)
        begin
            taken_vec <= irq_vector;
            taken_lvl <= irq_high_level;
            taken_cnt <= taken_cnt + 1;
        end
        if (irq_push_pc)
            push_cnt <= push_cnt + 1;
    end

    // One-cycle return pulse; callers keep it clear of an ack
    task automatic do_reti();
        @(negedge mclk);
        reti_exec = 1'b1;
        @(negedge mclk);
        reti_exec = 1'b0;
    endtask
endmodule

// ---- tlic_ctrl_tb.sv ----
// Purpose: Self-checking bench for the two-level interrupt controller
// Assumes: Inputs change on the falling edge; core model acks every offer
// Notes: Request flags are levels, so each is cleared once its vector is taken
`timescale 1ns/10ps

module tlic_ctrl_tb;
    logic mclk;
    logic nrst;
    logic [7:0] sfr_addr;
    logic sfr_wr;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic [12:0] flags;
    logic wd_mode;
    logic [3:0] wd_sel;
    logic irq_ack, reti_exec, irq_req, irq_push_pc, irq_high_level;
    logic [15:0] irq_vector;
    logic [1:0] active_levels;
    int errors;
    int cmp_count;
    int order [10] = '{0, 2, 3, 4, 5, 6, 7, 8, 9, 10};
    // Vectors by flag index: polling order, then uart tx and timer 2 external
    logic [15:0] vecs [13] = '{16'h0043, 16'h005b, 16'h0003, 16'h0033, 16'h000b,
        16'h0013, 16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053, 16'h0023, 16'h002b};

    // ==========================================================
    // Design and core model
    tlic_ctrl tlic_ctrl_i (.mclk(mclk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .supply_mon_request(flags[0]),
        .watchdog_timeout(flags[1]), .watchdog_irq_mode(wd_mode),
        .watchdog_timeout_sel(wd_sel), .ext0_request(flags[2]),
        .conv_done_request(flags[3]), .tmr0_overflow_flag(flags[4]),
        .ext1_request(flags[5]), .tmr1_overflow_flag(flags[6]), .spi_request(flags[7]),
        .uart_rx_flag(flags[8]), .uart_tx_flag(flags[11]), .tmr2_overflow_flag(flags[9]),
        .tmr2_external_flag(flags[12]), .interval_request(flags[10]), .irq_ack(irq_ack),
        .reti_exec(reti_exec), .irq_req(irq_req), .irq_vector(irq_vector),
        .irq_push_pc(irq_push_pc), .irq_high_level(irq_high_level),
        .active_levels(active_levels));

    tlic_core_model core_i (.mclk(mclk), .irq_req(irq_req), .irq_vector(irq_vector),
        .irq_high_level(irq_high_level), .irq_push_pc(irq_push_pc), .irq_ack(irq_ack),
        .reti_exec(reti_exec));

    // ==========================================================
    // Tasks
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge mclk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge mclk);
        sfr_wr = 1'b0;
    endtask

    // Read data is registered, so it is looked at one cycle after the address
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(negedge mclk);
        sfr_addr = a;
        @(negedge mclk);
        chk("sfr_rdata", {8'h00, exp}, {8'h00, sfr_rdata});
    endtask

    // Wait a bounded time for the vector of flag i, then check the push pulse
    task automatic take(int i, logic lvl);
        int n0;
        int k;
        n0 = core_i.taken_cnt;
        k = 0;
        while (core_i.taken_cnt == n0 && k < 20)
        begin
            @(negedge mclk);
            k++;
        end
        flags[i] = 1'b0;
        chk("taken count", 16'(n0 + 1), 16'(core_i.taken_cnt));
        chk("irq_vector", vecs[i], core_i.taken_vec);
        chk("irq_high_level", {15'h0, lvl}, {15'h0, core_i.taken_lvl});
        @(negedge mclk);
        chk("push count", 16'(core_i.taken_cnt), 16'(core_i.push_cnt));
    endtask

    task automatic no_take(int n);
        int n0;
        n0 = core_i.taken_cnt;
        repeat (n) @(negedge mclk);
        chk("no offer", 16'(n0), 16'(core_i.taken_cnt));
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ==========================================================
    // Clock and hang guard
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Whole run is well under a thousand cycles; this leaves ample margin
    initial
    begin
        repeat (5000) @(posedge mclk);
        errors++;
        wrap_up();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        errors = 0;
        cmp_count = 0;
        nrst = 1'b0;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        flags = 13'h0000;
        wd_mode = 1'b0;
        wd_sel = 4'h0;
        repeat (5) @(negedge mclk);
        nrst = 1'b1;
        // Reset values, write masks and an unmapped address
        rd(8'ha8, 8'h00);
        rd(8'ha9, 8'ha0);
        rd(8'hb8, 8'h00);
        wr(8'hb8, 8'hff);
        rd(8'hb8, 8'h7f);
        wr(8'ha9, 8'h77);
        rd(8'ha9, 8'h77);
        wr(8'hb9, 8'h55);
        rd(8'hb9, 8'h00);
        // All sources but the watchdog at once, first all low then all high
        wr(8'ha8, 8'hff);
        for (int p = 0; p < 2; p++)
        begin
            wr(8'hb8, p ? 8'h7f : 8'h00);
            wr(8'ha9, p ? 8'h77 : 8'h07);
            flags = 13'h07fd;
            foreach (order[j])
            begin
                take(order[j], p[0]);
                core_i.do_reti();
            end
        end
        // Second flag of the shared sources
        flags[11] = 1'b1;
        take(11, 1'b1);
        core_i.do_reti();
        flags[12] = 1'b1;
        take(12, 1'b1);
        core_i.do_reti();
        // Per-source enable, then the global gate
        wr(8'ha8, 8'hfe);
        flags[2] = 1'b1;
        no_take(6);
        wr(8'ha8, 8'h7f);
        no_take(6);
        wr(8'ha8, 8'hff);
        take(2, 1'b1);
        core_i.do_reti();
        // Mixed levels: simultaneous, preemption, same-level blocking
        wr(8'hb8, 8'h20);
        wr(8'ha9, 8'h07);
        flags[2] = 1'b1;
        flags[9] = 1'b1;
        take(9, 1'b1);
        no_take(4);
        core_i.do_reti();
        take(2, 1'b0);
        flags[12] = 1'b1;
        take(12, 1'b1);
        chk("active_levels", 16'h0003, {14'h0, active_levels});
        wr(8'hb8, 8'h28);
        flags[6] = 1'b1;
        no_take(6);
        core_i.do_reti();
        take(6, 1'b1);
        core_i.do_reti();
        repeat (2) @(negedge mclk);
        chk("active_levels", 16'h0001, {14'h0, active_levels});
        core_i.do_reti();
        repeat (2) @(negedge mclk);
        chk("active_levels", 16'h0000, {14'h0, active_levels});
        // Watchdog ignores the gate, needs a nonzero setting and interrupt mode
        wr(8'ha8, 8'h00);
        wd_mode = 1'b1;
        wd_sel = 4'h3;
        flags[1] = 1'b1;
        take(1, 1'b1);
        core_i.do_reti();
        wd_sel = 4'h0;
        flags[1] = 1'b1;
        no_take(6);
        wd_sel = 4'h3;
        wd_mode = 1'b0;
        no_take(6);
        flags[1] = 1'b0;
        wrap_up();
    end
endmodule
